// file: verilog/dcsf_top.sv
// control/status frame pair one: protection, pwm gating, diagnostics
`timescale 1ns/1ps
`default_nettype none
`include "dcsf_map.svh"
module dcsf_top
#(
   parameter int OPENLOAD_CYC = `DCSF_OPENLOAD_CYC,
   parameter int SETTLE_CYC   = `DCSF_SETTLE_CYC
)
(
   // clock and reset
   input  wire logic                      i_clock,
   input  wire logic                      i_arst_n,
   // serial link
   input  wire logic                      i_sclk,
   input  wire logic                      i_cs_n,
   input  wire logic                      i_mosi,
   output logic                           o_miso,
   output logic                           o_miso_oe_n,
   // analog senses (asynchronous)
   input  wire logic [`DCSF_STAGES-1:0]   i_overcurrent,
   input  wire logic [`DCSF_STAGES-1:0]   i_undercurrent,
   input  wire logic                      i_supply_under,
   input  wire logic                      i_supply_over,
   input  wire logic                      i_thermal_shutdown,
   input  wire logic                      i_thermal_warning,
   input  wire logic                      i_pulse_input_primary,
   input  wire logic                      i_pulse_input_secondary,
   // from frame pair zero (same clock)
   input  wire logic [`DCSF_STAGES-1:0]   i_stage_request,
   input  wire logic                      i_recovery_duty,
   input  wire logic [`DCSF_STAGES-1:0]   i_overcurrent_clear,
   input  wire logic                      i_thermal_clear,
   input  wire dcsf_pkg::dcsf_frame_t     i_status0_frame,
   // stage drive and status
   output logic [`DCSF_STAGES-1:0]        o_stage_on,
   output logic [1:0]                     o_low_current_mode,
   output logic [`DCSF_STAGES-1:0]        o_overcurrent_flag,
   output dcsf_pkg::dcsf_mode_t           o_mode
);
   import dcsf_pkg::*;
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_arst_n);
   dcsf_if bus ();
   logic [`DCSF_SYNC_W-1:0]  meta_q;
   logic [`DCSF_SYNC_W-1:0]  sync_q;
   dcsf_frame_t              ctl_q;
   dcsf_mode_t               mode_q;
   logic [`DCSF_TMR_W-1:0]   settle_q;
   logic                     tsd_q;
   logic                     tw_q;
   logic [`DCSF_STAGES-1:0]  oc_flag_q;
   logic [`DCSF_STAGES-1:0]  oc_off_q;
   logic [`DCSF_STAGES-1:0]  ol_flag_q;
   logic [`DCSF_STAGES-1:0]  stage_d;
   logic [`DCSF_STAGES-1:0]  oc_s;
   logic [`DCSF_STAGES-1:0]  uc_s;
   logic                     under_s;
   logic                     over_s;
   logic                     tsd_s;
   logic                     tw_s;
   logic                     pulse_input_primary_s;
   logic                     pulse_input_secondary_s;
   logic                     write_hit;
   logic                     standby;
   logic                     block_all;
   logic [`DCSF_OUTPUTS-1:0] rec_en;
   logic [`DCSF_OUTPUTS-1:0] pwm_en;
   dcsf_frame_t              status;

   dcsf_spi u_spi
   (
      .i_clock     (i_clock),
      .i_arst_n    (i_arst_n),
      .i_sclk      (i_sclk),
      .i_cs_n      (i_cs_n),
      .i_mosi      (i_mosi),
      .o_miso      (o_miso),
      .o_miso_oe_n (o_miso_oe_n),
      .bus         (bus.spi)
   );

   // every analog sense passes two flops before use
   always_ff @(posedge i_clock or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         meta_q <= '0;
         sync_q <= '0;
      end
      else
      begin
         meta_q <= {i_overcurrent, i_undercurrent, i_supply_under, i_supply_over, i_thermal_shutdown,
                    i_thermal_warning, i_pulse_input_primary, i_pulse_input_secondary};
         sync_q <= meta_q;
      end
   end
   assign {oc_s, uc_s, under_s, over_s, tsd_s, tw_s, pulse_input_primary_s, pulse_input_secondary_s} = sync_q;

   assign write_hit = bus.rx_valid && bus.rx_word[`DCSF_BIT_SELECT];
   assign standby   = !ctl_q[`DCSF_BIT_ENABLE];

   // control frame; ignored bits never stored
   always_ff @(posedge i_clock or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         ctl_q <= `DCSF_CTL_RESET;
      end
      else if (write_hit)
      begin
         if (bus.rx_word[`DCSF_BIT_ENABLE])
         begin
            ctl_q <= bus.rx_word & `DCSF_CTL_WRITE_MASK;
         end
         else
         begin
            ctl_q <= `DCSF_CTL_RESET;
         end
      end
   end

   assign rec_en = {ctl_q[`DCSF_BIT_REC_HEAVY_SWITCH_OUTPUT], ctl_q[`DCSF_BIT_REC_SWITCH_OUTPUT_E], ctl_q[`DCSF_BIT_REC_SWITCH_OUTPUT_D],
                    ctl_q[`DCSF_BIT_REC_BRIDGE_OUTPUT_C], ctl_q[`DCSF_BIT_REC_BRIDGE_OUTPUT_B], ctl_q[`DCSF_BIT_REC_BRIDGE_OUTPUT_A]};
   assign pwm_en = {ctl_q[`DCSF_BIT_PWM_HEAVY_SWITCH_OUTPUT], ctl_q[`DCSF_BIT_PWM_SWITCH_OUTPUT_E], ctl_q[`DCSF_BIT_PWM_SWITCH_OUTPUT_D],
                    ctl_q[`DCSF_BIT_PWM_BRIDGE_OUTPUT_C], ctl_q[`DCSF_BIT_PWM_BRIDGE_OUTPUT_B], ctl_q[`DCSF_BIT_PWM_BRIDGE_OUTPUT_A]};

   // settle timer runs on the internal clock so its length is a usable reference
   always_ff @(posedge i_clock or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         mode_q   <= DCSF_ST_STANDBY;
         settle_q <= '0;
      end
      else
      begin
         case (mode_q)
            DCSF_ST_STANDBY:
            begin
               settle_q <= '0;
               if (!standby)
               begin
                  mode_q <= DCSF_ST_SETTLE;
               end
            end
            DCSF_ST_SETTLE:
            begin
               settle_q <= settle_q + `DCSF_TMR_W'(1);
               if (standby)
               begin
                  mode_q <= DCSF_ST_STANDBY;
               end
               else if (settle_q == `DCSF_TMR_W'(SETTLE_CYC - 1))
               begin
                  mode_q <= DCSF_ST_ACTIVE;
               end
            end
            DCSF_ST_ACTIVE:
            begin
               if (standby)
               begin
                  mode_q <= DCSF_ST_STANDBY;
               end
            end
            default:
            begin
               mode_q <= DCSF_ST_STANDBY;
            end
         endcase
      end
   end

   // thermal flags latch; a new event beats the host clear
   always_ff @(posedge i_clock or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         tsd_q <= 1'b0;
         tw_q  <= 1'b0;
      end
      else if (standby)
      begin
         tsd_q <= 1'b0;
         tw_q  <= 1'b0;
      end
      else
      begin
         tsd_q <= tsd_s | (tsd_q & ~i_thermal_clear);
         tw_q  <= tw_s | (tw_q & ~i_thermal_clear);
      end
   end

   assign block_all = standby || (mode_q != DCSF_ST_ACTIVE) || tsd_q || tsd_s || under_s || over_s;

   genvar g;
   generate
      for (g = 0; g < `DCSF_STAGES; g++)
      begin : g_stage
         localparam int OUT = (g < `DCSF_STG_SWITCH_OUTPUT_D) ? (g / 2) : (g - 3);
         logic [11:0]            off_q;
         logic [`DCSF_TMR_W-1:0] ol_q;
         logic                   pulse;

         // off delay; duty bit trades retry rate against dissipation
         always_ff @(posedge i_clock or negedge i_arst_n)
         begin
            if (!i_arst_n)
            begin
               oc_flag_q[g] <= 1'b0;
               oc_off_q[g]  <= 1'b0;
               off_q        <= '0;
            end
            else if (standby)
            begin
               oc_flag_q[g] <= 1'b0;
               oc_off_q[g]  <= 1'b0;
               off_q        <= '0;
            end
            else if (oc_s[g] && o_stage_on[g])
            begin
               oc_flag_q[g] <= 1'b1;
               oc_off_q[g]  <= 1'b1;
               off_q        <= i_recovery_duty ? 12'(`DCSF_OFF_LONG_CYC - 1) : 12'(`DCSF_OFF_SHORT_CYC - 1);
            end
            else
            begin
               if (i_overcurrent_clear[g])
               begin
                  oc_flag_q[g] <= 1'b0;
               end
               if (off_q != '0)
               begin
                  off_q <= off_q - 12'(1);
               end
               if (rec_en[OUT] && off_q == '0)
               begin
                  oc_off_q[g] <= 1'b0;
               end
               else if (i_overcurrent_clear[g])
               begin
                  oc_off_q[g] <= 1'b0;
               end
            end
         end

         assign pulse = (g == `DCSF_STG_SWITCH_OUTPUT_E) ? pulse_input_secondary_s : pulse_input_primary_s;
         assign stage_d[g] = i_stage_request[g] && !block_all && !oc_off_q[g] && !oc_s[g]
                             && (!pwm_en[OUT] || pulse);

         // open-load filter; the flag is cleared when the host reads a frame while the stage is off or sees no under-current
         always_ff @(posedge i_clock or negedge i_arst_n)
         begin
            if (!i_arst_n)
            begin
               ol_q         <= '0;
               ol_flag_q[g] <= 1'b0;
            end
            else if (standby)
            begin
               ol_q         <= '0;
               ol_flag_q[g] <= 1'b0;
            end
            else if (o_stage_on[g] && uc_s[g])
            begin
               if (ol_q == `DCSF_TMR_W'(OPENLOAD_CYC - 1))
               begin
                  ol_flag_q[g] <= 1'b1;
               end
               else
               begin
                  ol_q <= ol_q + `DCSF_TMR_W'(1);
               end
            end
            else
            begin
               ol_q <= '0;
               if (bus.rx_valid)
               begin
                  ol_flag_q[g] <= 1'b0;
               end
            end
         end

         a_oc_stage_off: assert property (oc_s[g] |=> !o_stage_on[g])
            else $error("stage on after over-current");
         a_pwm_low_off: assert property (pwm_en[OUT] && !pulse |=> !o_stage_on[g])
            else $error("stage on while pulse input low");
      end
   endgenerate

   always_ff @(posedge i_clock or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         o_stage_on         <= '0;
         o_low_current_mode <= 2'h0;
      end
      else
      begin
         o_stage_on         <= stage_d;
         o_low_current_mode <= {ctl_q[`DCSF_BIT_HIGHR_SWITCH_OUTPUT_E], ctl_q[`DCSF_BIT_HIGHR_SWITCH_OUTPUT_D]};
      end
   end

   always_comb
   begin
      status                                        = '0;
      status[`DCSF_BIT_ALWAYS_ONE]                  = 1'b1;
      status[`DCSF_BIT_OVERVOLT]                    = over_s;
      status[`DCSF_BIT_UNDERVOLT]                   = under_s;
      status[`DCSF_BIT_TSD]                         = tsd_q;
      status[`DCSF_BIT_TW]                          = tw_q;
      status[`DCSF_BIT_NOTREADY]                    = (mode_q == DCSF_ST_SETTLE);
      status[`DCSF_BIT_OL_HEAVY_SWITCH_OUTPUT]                     = ol_flag_q[`DCSF_STG_HEAVY_SWITCH_OUTPUT];
      status[`DCSF_BIT_OL_SWITCH_OUTPUT_E]                     = ol_flag_q[`DCSF_STG_SWITCH_OUTPUT_E];
      status[`DCSF_BIT_OL_SWITCH_OUTPUT_D]                     = ol_flag_q[`DCSF_STG_SWITCH_OUTPUT_D];
      status[`DCSF_BIT_OL_FIRST +: `DCSF_STG_SWITCH_OUTPUT_D]  = ol_flag_q[`DCSF_STG_SWITCH_OUTPUT_D-1:0];
      status[`DCSF_BIT_NOERROR] = !(|status[`DCSF_FAULT_HI:`DCSF_FAULT_LO]
                                    || |i_status0_frame[`DCSF_FAULT_HI:`DCSF_FAULT_LO]);
   end

   assign bus.tx_word         = status;
   assign o_overcurrent_flag  = oc_flag_q;
   assign o_mode              = mode_q;

   a_tsd_blocks_out: assert property (tsd_q |=> o_stage_on == '0)
      else $error("stage on during thermal shutdown");
   a_supply_blocks_out: assert property (under_s || over_s |=> o_stage_on == '0)
      else $error("stage on during supply fault");
   a_notready_blocks: assert property (status[`DCSF_BIT_NOTREADY] |=> o_stage_on == '0)
      else $error("stage on while settling");
   a_settle_holds: assert property ($rose(status[`DCSF_BIT_NOTREADY]) && SETTLE_CYC > 8
                                    |-> (status[`DCSF_BIT_NOTREADY] || standby)[*8])
      else $error("not-ready too short");
   a_top_bit_one: assert property (bus.tx_word[`DCSF_BIT_ALWAYS_ONE])
      else $error("status bit 23 low");
   a_noerror_nor: assert property (bus.tx_word[`DCSF_BIT_NOERROR]
                                   == !(|{bus.tx_word[22:1], i_status0_frame[22:1]}))
      else $error("no-error bit wrong");
   a_zero_bits: assert property (bus.tx_word[16] == 1'b0 && bus.tx_word[13:7] == '0)
      else $error("reserved status bits set");
   a_ignored_bits: assert property ((ctl_q & ~`DCSF_CTL_WRITE_MASK) == '0)
      else $error("ignored control bit stored");
   a_standby_clear: assert property (standby |-> ctl_q == '0 ##1 (oc_flag_q == '0 && ol_flag_q == '0 && !tsd_q))
      else $error("standby left bits set");
   a_warn_sticky: assert property (tw_q && !i_thermal_clear && !standby |=> tw_q)
      else $error("warning cleared by itself");
endmodule
`default_nettype wire

// file: verilog/dcsf_map.svh
// bit positions, masks and timing constants of the control/status frame pair
`ifndef DCSF_MAP_SVH
`define DCSF_MAP_SVH
`define DCSF_FRAME_W         24
`define DCSF_BITCNT_W        5
`define DCSF_STAGES          9
`define DCSF_OUTPUTS         6
`define DCSF_SYNC_W          24
// control frame fields
`define DCSF_BIT_SELECT      0
`define DCSF_BIT_ENABLE      23
`define DCSF_BIT_REC_HEAVY_SWITCH_OUTPUT    22
`define DCSF_BIT_REC_SWITCH_OUTPUT_E    20
`define DCSF_BIT_REC_SWITCH_OUTPUT_D    19
`define DCSF_BIT_REC_BRIDGE_OUTPUT_C    14
`define DCSF_BIT_REC_BRIDGE_OUTPUT_B    13
`define DCSF_BIT_REC_BRIDGE_OUTPUT_A    12
`define DCSF_BIT_PWM_HEAVY_SWITCH_OUTPUT    11
`define DCSF_BIT_PWM_SWITCH_OUTPUT_E    9
`define DCSF_BIT_PWM_SWITCH_OUTPUT_D    8
`define DCSF_BIT_PWM_BRIDGE_OUTPUT_C    3
`define DCSF_BIT_PWM_BRIDGE_OUTPUT_B    2
`define DCSF_BIT_PWM_BRIDGE_OUTPUT_A    1
`define DCSF_BIT_HIGHR_SWITCH_OUTPUT_E  17
`define DCSF_BIT_HIGHR_SWITCH_OUTPUT_D  6
`define DCSF_CTL_WRITE_MASK  24'hda7b4e
`define DCSF_CTL_RESET       24'h000000
// status frame fields
`define DCSF_BIT_ALWAYS_ONE  23
`define DCSF_BIT_OVERVOLT    22
`define DCSF_BIT_UNDERVOLT   21
`define DCSF_BIT_TSD         20
`define DCSF_BIT_TW          19
`define DCSF_BIT_NOTREADY    18
`define DCSF_BIT_OL_HEAVY_SWITCH_OUTPUT     17
`define DCSF_BIT_OL_SWITCH_OUTPUT_E     15
`define DCSF_BIT_OL_SWITCH_OUTPUT_D     14
`define DCSF_BIT_OL_FIRST    1
`define DCSF_BIT_NOERROR     0
`define DCSF_FAULT_HI        22
`define DCSF_FAULT_LO        1
// stage indices: 0..5 bridge low/high pairs, then single switches
`define DCSF_STG_SWITCH_OUTPUT_D        6
`define DCSF_STG_SWITCH_OUTPUT_E        7
`define DCSF_STG_HEAVY_SWITCH_OUTPUT        8
// timing
`define DCSF_CLK_MHZ         100
`define DCSF_OFF_SHORT_US    10
`define DCSF_OFF_LONG_US     40
`define DCSF_OFF_SHORT_CYC   (`DCSF_OFF_SHORT_US * `DCSF_CLK_MHZ)
`define DCSF_OFF_LONG_CYC    (`DCSF_OFF_LONG_US * `DCSF_CLK_MHZ)
`define DCSF_OPENLOAD_US     1000
`define DCSF_OPENLOAD_CYC    (`DCSF_OPENLOAD_US * `DCSF_CLK_MHZ)
`define DCSF_SETTLE_US       100
`define DCSF_SETTLE_CYC      (`DCSF_SETTLE_US * `DCSF_CLK_MHZ)
`define DCSF_TMR_W           17
`endif

// file: verilog/dcsf_pkg.sv
// types shared by the frame pair logic
package dcsf_pkg;
   typedef logic [23:0] dcsf_frame_t;
   typedef enum logic [2:0]
   {
      DCSF_ST_STANDBY = 3'b001,
      DCSF_ST_SETTLE  = 3'b010,
      DCSF_ST_ACTIVE  = 3'b100
   } dcsf_mode_t;
endpackage

// file: verilog/dcsf_if.sv
// frame carrier between serial shifter and register core
`timescale 1ns/1ps
`default_nettype none
interface dcsf_if;
   import dcsf_pkg::*;
   dcsf_frame_t rx_word;
   logic        rx_valid;
   dcsf_frame_t tx_word;
   modport spi  (output rx_word, output rx_valid, input tx_word);
   modport core (input rx_word, input rx_valid, output tx_word);
endinterface
`default_nettype wire

// file: verilog/dcsf_spi.sv
// serial shifter: oversamples the link pins and moves 24-bit frames
`timescale 1ns/1ps
`default_nettype none
`include "dcsf_map.svh"
module dcsf_spi
(
   // clock and reset
   input  wire logic  i_clock,
   input  wire logic  i_arst_n,
   // link pins
   input  wire logic  i_sclk,
   input  wire logic  i_cs_n,
   input  wire logic  i_mosi,
   output logic       o_miso,
   output logic       o_miso_oe_n,
   // frame side
   dcsf_if.spi        bus
);
   import dcsf_pkg::*;
   logic [2:0]                meta_q;
   logic [2:0]                sync_q;
   logic [1:0]                prev_q;
   dcsf_frame_t               rx_q;
   dcsf_frame_t               tx_q;
   logic [`DCSF_BITCNT_W-1:0] cnt_q;
   logic                      valid_q;
   logic                      sclk_rise;
   logic                      sclk_fall;
   logic                      cs_fall;
   logic                      cs_rise;

   always_ff @(posedge i_clock or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         meta_q <= 3'h2;
         sync_q <= 3'h2;
         prev_q <= 2'h2;
      end
      else
      begin
         meta_q <= {i_mosi, i_cs_n, i_sclk};
         sync_q <= meta_q;
         prev_q <= sync_q[1:0];
      end
   end

   assign sclk_rise = sync_q[0] & ~prev_q[0] & ~sync_q[1];
   assign sclk_fall = ~sync_q[0] & prev_q[0] & ~sync_q[1];
   assign cs_fall   = ~sync_q[1] & prev_q[1];
   assign cs_rise   = sync_q[1] & ~prev_q[1];

   // sample on rising edge, shift out on falling edge, msb first
   always_ff @(posedge i_clock or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         rx_q  <= '0;
         tx_q  <= '0;
         cnt_q <= '0;
      end
      else if (cs_fall)
      begin
         tx_q  <= bus.tx_word;
         cnt_q <= '0;
      end
      else if (sclk_rise)
      begin
         rx_q  <= {rx_q[`DCSF_FRAME_W-2:0], sync_q[2]};
         cnt_q <= cnt_q + `DCSF_BITCNT_W'(1);
      end
      else if (sclk_fall)
      begin
         tx_q <= {tx_q[`DCSF_FRAME_W-2:0], 1'b0};
      end
   end

   // a frame whose length is not 24 bits modulo 32 is dropped whole
   always_ff @(posedge i_clock or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         valid_q <= 1'b0;
      end
      else
      begin
         valid_q <= cs_rise && (cnt_q == `DCSF_BITCNT_W'(`DCSF_FRAME_W));
      end
   end

   always_ff @(posedge i_clock or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         o_miso      <= 1'b0;
         o_miso_oe_n <= 1'b1;
      end
      else
      begin
         o_miso      <= cs_fall ? bus.tx_word[`DCSF_FRAME_W-1] : tx_q[`DCSF_FRAME_W-1];
         o_miso_oe_n <= sync_q[1];
      end
   end

   assign bus.rx_word  = rx_q;
   assign bus.rx_valid = valid_q;
endmodule
`default_nettype wire

// file: verilog/dcsf_files_end.sv
// intentionally empty compile unit marker
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// file: sim/dcsf_host.sv
// behavioural host master exchanging 24-bit frames on the serial link
`timescale 1ns/1ps
`default_nettype none
module dcsf_host
(
   // clock and link
   input  wire logic i_clock,
   input  wire logic i_miso,
   output logic      o_sclk,
   output logic      o_cs_n,
   output logic      o_mosi
);
   import dcsf_pkg::*;
   initial
   begin
      o_sclk = 1'b0;
      o_cs_n = 1'b1;
      o_mosi = 1'b0;
   end
   // sclk stands still outside frames; 16 clocks per bit gives the 160 ns link period
   task automatic xfer(input dcsf_frame_t w, output dcsf_frame_t r);
      @(posedge i_clock);
      o_cs_n <= 1'b0;
      repeat (8) @(posedge i_clock);
      for (int i = 23; i >= 0; i--)
      begin
         o_mosi <= w[i];
         repeat (8) @(posedge i_clock);
         o_sclk <= 1'b1;
         r[i] = i_miso;
         repeat (8) @(posedge i_clock);
         o_sclk <= 1'b0;
      end
      repeat (8) @(posedge i_clock);
      o_cs_n <= 1'b1;
      // released line shows the inverse so a stale bit is never mistaken for data
      o_mosi <= ~w[0];
      repeat (6) @(posedge i_clock);
   endtask
endmodule
`default_nettype wire

// file: sim/dcsf_top_tb.sv
// self-checking bench for control/status frame pair one
`timescale 1ns/1ps
`default_nettype none
module dcsf_top_tb;
   import dcsf_pkg::*;
   localparam dcsf_frame_t CTL = 24'ha21a51;
   logic        clock = 1'b0;
   logic        arst_n = 1'b0;
   logic        sclk;
   logic        cs_n;
   logic        mosi;
   logic        miso;
   logic        oe_n;
   logic [8:0]  oc = 9'h000;
   logic [8:0]  uc = 9'h000;
   logic [8:0]  oc_clr = 9'h000;
   logic [8:0]  stage_on;
   logic [8:0]  oc_flag;
   logic        s_under = 1'b0;
   logic        s_over = 1'b0;
   dcsf_frame_t s0 = 24'h000000;
   logic        thermal_shutdown_flag = 1'b0;
   logic        tw = 1'b0;
   logic        pp = 1'b0;
   logic        ps = 1'b1;
   logic        t_clr = 1'b0;
   logic [1:0]  low_cur;
   dcsf_mode_t  mode;
   dcsf_frame_t r;
   int          mismatches = 0;
   int          checked = 0;
   always #5 clock = ~clock;
   dcsf_top #(.OPENLOAD_CYC(50), .SETTLE_CYC(500)) i_dcsf_top
   (
      .i_clock(clock), .i_arst_n(arst_n), .i_sclk(sclk), .i_cs_n(cs_n), .i_mosi(mosi),
      .o_miso(miso), .o_miso_oe_n(oe_n), .i_overcurrent(oc), .i_undercurrent(uc),
      .i_supply_under(s_under), .i_supply_over(s_over), .i_thermal_shutdown(thermal_shutdown_flag),
      .i_thermal_warning(tw), .i_pulse_input_primary(pp), .i_pulse_input_secondary(ps),
      .i_stage_request(9'h1ff), .i_recovery_duty(1'b0), .i_overcurrent_clear(oc_clr),
      .i_thermal_clear(t_clr), .i_status0_frame(s0), .o_stage_on(stage_on),
      .o_low_current_mode(low_cur), .o_overcurrent_flag(oc_flag), .o_mode(mode)
   );
   dcsf_host i_dcsf_host
   (
      .i_clock(clock), .i_miso(miso), .o_sclk(sclk), .o_cs_n(cs_n), .o_mosi(mosi)
   );
   task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
      checked++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
   endtask
   task automatic print_verdict;
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic t_enable;
      fork
         i_dcsf_host.xfer(24'h000001, r);
         begin
            tick(20);
            chk("oe driving", 24'(oe_n), 24'h0);
         end
      join
      chk("oe released", 24'(oe_n), 24'h1);
      chk("idle reply", r, 24'h800001);
      i_dcsf_host.xfer(24'h800001, r);
      tick(4);
      chk("mode settle", 24'(mode), 24'(DCSF_ST_SETTLE));
      i_dcsf_host.xfer(CTL, r);
      chk("settle reply", r, 24'h840000);
      chk("settle dark", 24'(stage_on), 24'h0);
      tick(120);
      chk("mode active", 24'(mode), 24'(DCSF_ST_ACTIVE));
      $display("test enable done");
   endtask
   task automatic t_pwm;
      chk("low current", 24'(low_cur), 24'h3);
      chk("pwm low", 24'(stage_on), 24'h0ff);
      pp <= 1'b1;
      ps <= 1'b0;
      tick(8);
      chk("pwm high", 24'(stage_on), 24'h17f);
      $display("test pwm done");
   endtask
   task automatic t_oc;
      oc <= 9'h005;
      tick(4);
      oc <= 9'h000;
      tick(500);
      chk("oc flag", 24'(oc_flag), 24'h005);
      chk("oc off", 24'(stage_on), 24'h17a);
      tick(700);
      chk("retry", 24'(stage_on), 24'h17b);
      oc_clr <= 9'h005;
      tick(1);
      oc_clr <= 9'h000;
      tick(8);
      chk("oc clear", 24'(oc_flag), 24'h0);
      chk("oc back", 24'(stage_on), 24'h17f);
      $display("test overcurrent done");
   endtask
   task automatic t_fault;
      thermal_shutdown_flag <= 1'b1;
      tw <= 1'b1;
      tick(4);
      thermal_shutdown_flag <= 1'b0;
      tw <= 1'b0;
      tick(8);
      chk("tsd off", 24'(stage_on), 24'h0);
      i_dcsf_host.xfer(CTL, r);
      chk("tsd reply", r, 24'h980000);
      chk("tsd held", 24'(stage_on), 24'h0);
      t_clr <= 1'b1;
      tick(1);
      t_clr <= 1'b0;
      tick(8);
      chk("tsd cleared", 24'(stage_on), 24'h17f);
      s_under <= 1'b1;
      tick(8);
      chk("uv off", 24'(stage_on), 24'h0);
      s_under <= 1'b0;
      tick(8);
      chk("uv back", 24'(stage_on), 24'h17f);
      s_over <= 1'b1;
      tick(8);
      chk("ov off", 24'(stage_on), 24'h0);
      i_dcsf_host.xfer(CTL, r);
      chk("ov reply", r, 24'hc00000);
      s_over <= 1'b0;
      s0 <= 24'h000400;
      tick(8);
      chk("ov back", 24'(stage_on), 24'h17f);
      i_dcsf_host.xfer(CTL, r);
      chk("pair zero fault", r, 24'h800000);
      s0 <= 24'h000000;
      $display("test fault done");
   endtask
   task automatic t_leave;
      uc <= 9'h100;
      tick(80);
      i_dcsf_host.xfer(CTL, r);
      uc <= 9'h000;
      chk("open load", r, 24'h820000);
      i_dcsf_host.xfer(24'h800000, r);
      tick(4);
      chk("no select", 24'(mode), 24'(DCSF_ST_ACTIVE));
      i_dcsf_host.xfer(24'h000001, r);
      tick(4);
      chk("standby", 24'(mode), 24'(DCSF_ST_STANDBY));
      chk("standby off", 24'(stage_on), 24'h0);
      chk("standby mode", 24'(low_cur), 24'h0);
      $display("test openload and standby done");
   endtask
   initial
   begin
      tick(4);
      arst_n <= 1'b1;
      tick(3);
      t_enable;
      t_pwm;
      t_oc;
      t_fault;
      t_leave;
      print_verdict;
   end
   // nine frames of about 410 clocks plus some 1500 of waits; generous margin
   initial
   begin
      tick(20000);
      mismatches++;
      print_verdict;
   end
endmodule
`default_nettype wire
